/* logic/dios_top.sv */
// Purpose: general purpose io pin with action trigger and step/dir driver port
// Assumes: AHB-Lite single word transfers, motion core on the same clock
// Notes: zero wait states; pin is a split in/out/oe triple
//
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "dios_cfg.svh"

module dios_top #(
  parameter logic [19:0] DEB_CYCLES = 20'(`DIOS_DEB_CYC)
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic        gpio_in,
  output var  logic        gpio_out,
  output var  logic        gpio_oe,
  input  wire logic        motion_moving,
  input  wire logic        motion_windings_on,
  input  wire logic        motion_motor_present,
  input  wire logic        motion_step_req,
  input  wire logic        motion_step_dir,
  output var  logic        quick_stop_cmd,
  output var  logic        winding_power_off_cmd,
  output var  logic        relative_shift_cmd,
  output var  logic        home_cmd,
  output var  logic        bridge_off,
  output var  logic        drv_enable,
  output var  logic        drv_dir,
  output var  logic        drv_step,
  output var  logic        irq
);

  // register select, shared by read and write decode
  function automatic logic [2:0] reg_sel(input logic [31:0] a);
    logic [7:0] o;
    o = a[7:0];
    if (a[31:8] != 24'h00_0000) begin
      reg_sel = 3'h0;
    end else if (o == `DIOS_OFS_CTRL) begin
      reg_sel = 3'h1;
    end else if (o == `DIOS_OFS_STATUS) begin
      reg_sel = 3'h2;
    end else if (o == `DIOS_OFS_INT_STAT) begin
      reg_sel = 3'h3;
    end else if (o == `DIOS_OFS_INT_CLR) begin
      reg_sel = 3'h4;
    end else if (o == `DIOS_OFS_INT_EN) begin
      reg_sel = 3'h5;
    end else begin
      reg_sel = 3'h0;
    end
  endfunction

  // pin synchroniser; first stage feeds only the second
  logic pin_s1_q;
  logic pin_s2_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= gpio_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  logic [31:0]                 ctrl_q;
  logic [31:0]                 ctrl_d;
  logic [`DIOS_INT_W-1:0]      int_stat_q;
  logic [`DIOS_INT_W-1:0]      int_stat_d;
  logic [`DIOS_INT_W-1:0]      int_en_q;
  logic [`DIOS_INT_W-1:0]      int_en_d;
  logic                        wr_pend_q;
  logic                        wr_pend_d;
  logic [2:0]                  wr_sel_q;
  logic [2:0]                  wr_sel_d;
  logic [31:0]                 hrdata_d;
  logic                        alarm_q;
  logic                        alarm_d;
  logic                        in_level_q;
  logic                        in_level_d;
  logic                        gpio_out_d;
  logic                        gpio_oe_d;
  logic                        drv_enable_d;
  logic                        cmd_stop_d;
  logic                        cmd_winding_power_off_cmd_d;
  logic                        cmd_shift_d;
  logic                        cmd_home_d;
  logic                        irq_d;
  logic                        fire;
  logic                        step_busy;
  logic                        step_drop;
  logic                        in_active;
  logic                        out_mode;
  logic                        invert;
  logic                        ext_en;
  logic                        evt_level;
  logic                        reinit;
  logic                        addr_ok;
  logic [2:0]                  addr_sel;
  dios_pkg::dios_action_t      action;
  dios_pkg::dios_out_event_t   out_evt;

  // control fields
  assign out_mode = ctrl_q[`DIOS_CTRL_OUT_MODE];
  assign invert   = ctrl_q[`DIOS_CTRL_INVERT];
  assign ext_en   = ctrl_q[`DIOS_CTRL_EXT_EN];
  assign action   = dios_pkg::dios_action_t'(ctrl_q[`DIOS_CTRL_ACT_HI:`DIOS_CTRL_ACT_LO]);
  assign out_evt  = dios_pkg::dios_out_event_t'(ctrl_q[`DIOS_CTRL_EVT_HI:`DIOS_CTRL_EVT_LO]);
  assign addr_ok  = hsel && hready && htrans[1];
  assign addr_sel = reg_sel(haddr);
  assign reinit   = wr_pend_q && (wr_sel_q == 3'h1) && hwdata[`DIOS_CTRL_REINIT];

  // level after inversion; an invert flip alone can make it active
  assign in_active = (pin_s2_q ^ invert) && !out_mode && !ext_en;

  // debounce restarts from zero at reset, so a level already active fires
  dios_debounce #(
    .DEB_CYCLES (DEB_CYCLES)
  ) u_deb (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .active_in (in_active),
    .fire_q    (fire)
  );

  dios_step_gen u_step (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .enable   (ext_en && !alarm_q),
    .step_req (motion_step_req),
    .step_dir (motion_step_dir),
    .step_q   (drv_step),
    .dir_q    (drv_dir),
    .busy_q   (step_busy),
    .drop_q   (step_drop)
  );

  // event selected for output mode
  always_comb begin
    case (out_evt)
      dios_pkg::out_on_motion:           evt_level = motion_moving;
      dios_pkg::out_on_alarm:            evt_level = alarm_q;
      dios_pkg::out_on_windings_powered: evt_level = motion_windings_on && !alarm_q;
      default:                           evt_level = motion_motor_present;
    endcase
  end

  // actions, alarm, pin and driver enable
  always_comb begin
    cmd_stop_d  = 1'b0;
    cmd_winding_power_off_cmd_d  = 1'b0;
    cmd_shift_d = 1'b0;
    cmd_home_d  = 1'b0;
    alarm_d     = alarm_q;
    if (reinit) begin
      alarm_d = 1'b0;
    end
    if (fire) begin
      case (action)
        dios_pkg::act_quick_stop: cmd_stop_d  = 1'b1;
        dios_pkg::act_power_off:  cmd_winding_power_off_cmd_d  = 1'b1;
        dios_pkg::act_rel_shift:  cmd_shift_d = 1'b1;
        dios_pkg::act_home:       cmd_home_d  = 1'b1;
        dios_pkg::act_alarm:      alarm_d     = 1'b1;
        default:                  alarm_d     = alarm_d;
      endcase
    end
    in_level_d   = (pin_s2_q ^ invert) && !out_mode && !ext_en;
    drv_enable_d = ext_en && motion_windings_on && !alarm_d;
    if (ext_en) begin
      gpio_out_d = drv_enable_d;
      gpio_oe_d  = 1'b1;
    end else if (out_mode) begin
      gpio_out_d = evt_level ^ invert;
      gpio_oe_d  = 1'b1;
    end else begin
      gpio_out_d = 1'b0;
      gpio_oe_d  = 1'b0;
    end
  end

  // bus slave: address phase is latched, write lands in the data phase
  always_comb begin
    ctrl_d     = ctrl_q;
    int_en_d   = int_en_q;
    int_stat_d = int_stat_q;
    wr_pend_d  = addr_ok && hwrite;
    wr_sel_d   = addr_sel;
    hrdata_d   = 32'h0000_0000;
    if (wr_pend_q) begin
      if (wr_sel_q == 3'h1) begin
        ctrl_d = hwdata & `DIOS_CTRL_MASK;
      end else if (wr_sel_q == 3'h4) begin
        int_stat_d = int_stat_q & ~hwdata[`DIOS_INT_W-1:0];
      end else if (wr_sel_q == 3'h5) begin
        int_en_d = hwdata[`DIOS_INT_W-1:0];
      end
    end
    // hardware events set after the clear, so a same-cycle event survives
    if (fire) begin
      int_stat_d[`DIOS_INT_ACTION] = 1'b1;
    end
    if (alarm_d && !alarm_q) begin
      int_stat_d[`DIOS_INT_ALARM] = 1'b1;
    end
    if (step_drop) begin
      int_stat_d[`DIOS_INT_DROP] = 1'b1;
    end
    if (addr_ok && !hwrite) begin
      if (addr_sel == 3'h1) begin
        hrdata_d = ctrl_q;
      end else if (addr_sel == 3'h2) begin
        hrdata_d = {27'h000_0000, drv_enable, step_busy, gpio_out, alarm_q, in_level_q};
      end else if (addr_sel == 3'h3) begin
        hrdata_d = {29'h0000_0000, int_stat_q};
      end else if (addr_sel == 3'h5) begin
        hrdata_d = {29'h0000_0000, int_en_q};
      end
    end
    irq_d = |(int_stat_d & int_en_d);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q                <= `DIOS_CTRL_RST;
      int_stat_q            <= '0;
      int_en_q              <= '0;
      wr_pend_q             <= 1'b0;
      wr_sel_q              <= 3'h0;
      hrdata                <= 32'h0000_0000;
      hreadyout             <= 1'b1;
      hresp                 <= 1'b0;
      alarm_q               <= 1'b0;
      in_level_q            <= 1'b0;
      gpio_out              <= 1'b0;
      gpio_oe               <= 1'b0;
      drv_enable            <= 1'b0;
      quick_stop_cmd        <= 1'b0;
      winding_power_off_cmd <= 1'b0;
      relative_shift_cmd    <= 1'b0;
      home_cmd              <= 1'b0;
      bridge_off            <= 1'b0;
      irq                   <= 1'b0;
    end else begin
      ctrl_q                <= ctrl_d;
      int_stat_q            <= int_stat_d;
      int_en_q              <= int_en_d;
      wr_pend_q             <= wr_pend_d;
      wr_sel_q              <= wr_sel_d;
      hrdata                <= hrdata_d;
      hreadyout             <= 1'b1;
      hresp                 <= 1'b0;
      alarm_q               <= alarm_d;
      in_level_q            <= in_level_d;
      gpio_out              <= gpio_out_d;
      gpio_oe               <= gpio_oe_d;
      drv_enable            <= drv_enable_d;
      quick_stop_cmd        <= cmd_stop_d;
      winding_power_off_cmd <= cmd_winding_power_off_cmd_d;
      relative_shift_cmd    <= cmd_shift_d;
      home_cmd              <= cmd_home_d;
      bridge_off            <= alarm_d;
      irq                   <= irq_d;
    end
  end

  property p_alarm_bridge;
    @(posedge sys_clk) disable iff (rst)
    fire && (action == dios_pkg::act_alarm) |=> bridge_off && !drv_enable;
  endproperty
  a_alarm_bridge: assert property (p_alarm_bridge) else $error("alarm left bridges on");

  property p_alarm_holds;
    @(posedge sys_clk) disable iff (rst)
    alarm_q && !reinit |=> alarm_q;
  endproperty
  a_alarm_holds: assert property (p_alarm_holds) else $error("alarm dropped early");

  property p_ext_pin;
    @(posedge sys_clk) disable iff (rst)
    ext_en && $past(ext_en) |-> gpio_oe && (gpio_out == drv_enable) && !fire;
  endproperty
  a_ext_pin: assert property (p_ext_pin) else $error("pin not handed to driver");

  property p_action_pulse;
    @(posedge sys_clk) disable iff (rst)
    fire && (action == dios_pkg::act_power_off) |=> winding_power_off_cmd ##1 !winding_power_off_cmd;
  endproperty
  a_action_pulse: assert property (p_action_pulse) else $error("power off not issued");

endmodule // dios_top
`default_nettype wire

/* logic/dios_cfg.svh */
// Purpose: constants of the digital io and step output block
// Assumes: 100 MHz system clock
// Notes on behaviour
// - pin works as input or output
// - high active by default, invert bit flips
// - input logical state shown in status word
// - active input launches the selected action
// - alarm action turns bridges off until reinit
// - inversion change arms trigger like voltage
// - action fires after over 3 ms active
// - active at reset fires action too
// - output mode drives pin from chosen event
// - three driver outputs: enable, direction, step
// - direction high right, low left
// - one step pulse per microstep
// - step clock never above 78 kHz
// - driver mode takes over the shared pin
`ifndef DIOS_CFG_SVH
`define DIOS_CFG_SVH

`define DIOS_CLK_HZ        100000000
`define DIOS_DEB_TIME_MS   3
`define DIOS_DEB_CYC       (`DIOS_DEB_TIME_MS * (`DIOS_CLK_HZ / 1000))
`define DIOS_STEP_FMAX_HZ  78000
`define DIOS_STEP_MIN_CYC  ((`DIOS_CLK_HZ + `DIOS_STEP_FMAX_HZ - 1) / `DIOS_STEP_FMAX_HZ)
`define DIOS_STEP_HI_CYC   (`DIOS_STEP_MIN_CYC / 2)

// register byte offsets
`define DIOS_OFS_CTRL      8'h00
`define DIOS_OFS_STATUS    8'h04
`define DIOS_OFS_INT_STAT  8'h08
`define DIOS_OFS_INT_CLR   8'h0c
`define DIOS_OFS_INT_EN    8'h10

// control fields
`define DIOS_CTRL_OUT_MODE 0
`define DIOS_CTRL_INVERT   1
`define DIOS_CTRL_ACT_LO   2
`define DIOS_CTRL_ACT_HI   4
`define DIOS_CTRL_EVT_LO   5
`define DIOS_CTRL_EVT_HI   6
`define DIOS_CTRL_EXT_EN   7
`define DIOS_CTRL_REINIT   8
`define DIOS_CTRL_MASK     32'h0000_00ff
`define DIOS_CTRL_RST      32'h0000_0000

// interrupt bits
`define DIOS_INT_ACTION    0
`define DIOS_INT_ALARM     1
`define DIOS_INT_DROP      2
`define DIOS_INT_W         3

`define DIOS_PEND_W        8

`endif

/* logic/dios_pkg.sv */
// Purpose: shared types of the digital io and step output block
// Assumes: constants live in dios_cfg.svh
// Notes: enums carry no explicit codes
package dios_pkg;

  // action launched by a qualified input activation
  typedef enum logic [2:0] {
    act_quick_stop,
    act_power_off,
    act_rel_shift,
    act_home,
    act_alarm
  } dios_action_t;

  // event shown on the pin in output mode
  typedef enum logic [1:0] {
    out_on_motion,
    out_on_alarm,
    out_on_windings_powered,
    out_on_motor_present
  } dios_out_event_t;

  typedef enum logic [1:0] {
    step_idle,
    step_high,
    step_low
  } dios_step_state_t;

endpackage

/* logic/dios_debounce.sv */
// Purpose: qualifies an active level held longer than the debounce time
// Assumes: active_in already synchronised to sys_clk
// Notes: one fire pulse per activation
`timescale 1ns/1ps
`default_nettype none
`include "dios_cfg.svh"

module dios_debounce #(
  parameter logic [19:0] DEB_CYCLES = 20'(`DIOS_DEB_CYC)
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic active_in,
  output var  logic fire_q
);

  logic [19:0] cnt_q;
  logic [19:0] cnt_d;
  logic        done_q;
  logic        done_d;
  logic        fire_d;

  // count while active; a drop restarts, a qualified hold fires once
  always_comb begin
    cnt_d  = cnt_q;
    done_d = done_q;
    fire_d = 1'b0;
    if (!active_in) begin
      cnt_d  = 20'h0_0000;
      done_d = 1'b0;
    end else if (!done_q) begin
      if (cnt_q == DEB_CYCLES) begin
        fire_d = 1'b1;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 20'h0_0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q  <= 20'h0_0000;
      done_q <= 1'b0;
      fire_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
      fire_q <= fire_d;
    end
  end

  property p_fire_once;
    @(posedge sys_clk) disable iff (rst)
    fire_q |=> !fire_q;
  endproperty
  a_fire_once: assert property (p_fire_once) else $error("debounce fired twice");

  property p_fire_after_hold;
    @(posedge sys_clk) disable iff (rst)
    fire_q |-> ($past(cnt_q) == DEB_CYCLES) && $past(active_in);
  endproperty
  a_fire_after_hold: assert property (p_fire_after_hold) else $error("fire without hold");

endmodule // dios_debounce
`default_nettype wire

/* logic/dios_step_gen.sv */
// Purpose: emits one step pulse per requested microstep with direction
// Assumes: step_req is a one-cycle pulse from the motion core
// Notes: requests queue in a small counter; pulse rate capped
`timescale 1ns/1ps
`default_nettype none
`include "dios_cfg.svh"

module dios_step_gen (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic step_req,
  input  wire logic step_dir,
  output var  logic step_q,
  output var  logic dir_q,
  output var  logic busy_q,
  output var  logic drop_q
);

  dios_pkg::dios_step_state_t st_q;
  dios_pkg::dios_step_state_t st_d;
  logic [`DIOS_PEND_W-1:0] pend_q;
  logic [`DIOS_PEND_W-1:0] pend_d;
  logic [11:0]             tm_q;
  logic [11:0]             tm_d;
  logic                    step_d;
  logic                    dir_d;
  logic                    drop_d;
  logic                    take;

  // queue plus pulse sequencer; high phase, low phase and one idle cycle make one period
  always_comb begin
    st_d   = st_q;
    tm_d   = tm_q;
    step_d = step_q;
    dir_d  = dir_q;
    take   = 1'b0;
    drop_d = 1'b0;
    case (st_q)
      dios_pkg::step_idle: begin
        dir_d = step_dir;
        // a pulse waits one cycle when direction moves, so dir settles before the rise
        if ((pend_q != '0) && (dir_q == step_dir)) begin
          take   = 1'b1;
          step_d = 1'b1;
          tm_d   = 12'h000;
          st_d   = dios_pkg::step_high;
        end
      end
      dios_pkg::step_high: begin
        tm_d = tm_q + 12'h001;
        if (tm_q == 12'(`DIOS_STEP_HI_CYC - 1)) begin
          step_d = 1'b0;
          st_d   = dios_pkg::step_low;
        end
      end
      default: begin
        tm_d = tm_q + 12'h001;
        // full period before the next rise caps the rate
        if (tm_q == 12'(`DIOS_STEP_MIN_CYC - 2)) begin
          st_d = dios_pkg::step_idle;
        end
      end
    endcase
    pend_d = pend_q - (take ? `DIOS_PEND_W'(1) : `DIOS_PEND_W'(0));
    if (step_req && enable) begin
      if (pend_d == '1) begin
        drop_d = 1'b1;
      end else begin
        pend_d = pend_d + `DIOS_PEND_W'(1);
      end
    end
    if (!enable) begin
      pend_d = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q   <= dios_pkg::step_idle;
      tm_q   <= 12'h000;
      pend_q <= '0;
      step_q <= 1'b0;
      dir_q  <= 1'b0;
      busy_q <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      tm_q   <= tm_d;
      pend_q <= pend_d;
      step_q <= step_d;
      dir_q  <= dir_d;
      busy_q <= (pend_d != '0) || (st_d != dios_pkg::step_idle);
      drop_q <= drop_d;
    end
  end

  // helper: cycles since the last rising step edge
  logic [11:0] gap_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gap_q <= 12'hfff;
    end else if (step_d && !step_q) begin
      gap_q <= 12'h000;
    end else if (gap_q != 12'hfff) begin
      gap_q <= gap_q + 12'h001;
    end
  end

  property p_step_spacing;
    @(posedge sys_clk) disable iff (rst)
    $rose(step_q) |-> (gap_q == 12'h000) && ($past(gap_q) >= 12'(`DIOS_STEP_MIN_CYC - 1));
  endproperty
  a_step_spacing: assert property (p_step_spacing) else $error("step rate too high");

  property p_step_width;
    @(posedge sys_clk) disable iff (rst)
    $rose(step_q) |-> step_q[*8];
  endproperty
  a_step_width: assert property (p_step_width) else $error("step pulse too short");

  property p_dir_stable;
    @(posedge sys_clk) disable iff (rst)
    step_q |-> $stable(dir_q);
  endproperty
  a_dir_stable: assert property (p_dir_stable) else $error("direction moved in pulse");

  property p_no_step_empty;
    @(posedge sys_clk) disable iff (rst)
    (st_q == dios_pkg::step_idle) && (pend_q == '0) |=> !step_q;
  endproperty
  a_no_step_empty: assert property (p_no_step_empty) else $error("step without request");

endmodule // dios_step_gen
`default_nettype wire

/* tb/dios_ext_partner.sv */
// Purpose: far side of the pin and step port: outside equipment plus power driver
// Assumes: pin has a weak pull-down when nobody drives it
// Notes: counts step rises per direction and the closest rise spacing seen
`timescale 1ns/1ps
`default_nettype none

module dios_ext_partner (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic drv_enable,
  input  wire logic drv_dir,
  input  wire logic drv_step,
  input  wire logic gpio_out,
  input  wire logic gpio_oe,
  input  wire logic ext_oe,
  input  wire logic ext_lvl,
  output var  logic pin,
  output var  int   right_cnt,
  output var  int   left_cnt,
  output var  int   min_gap,
  output var  int   bad_cnt
);
  logic step_d;
  int   gap;

  // block wins the pin when it drives, else the equipment, else the pull-down
  assign pin = gpio_oe ? gpio_out : (ext_oe ? ext_lvl : 1'b0);

  // driver set to the same division: one rise moves one microstep
  always @(posedge sys_clk) begin
    step_d <= drv_step;
    // zero means no rise seen yet; the first rise has nothing to measure against
    if (gap != 0) gap <= gap + 1;
    if (rst) begin
      right_cnt <= 0;
      left_cnt <= 0;
      bad_cnt <= 0;
      min_gap <= 32'h7fff_ffff;
      gap <= 0;
    end else if (drv_step === 1'b1 && step_d === 1'b0) begin
      if (drv_dir) right_cnt <= right_cnt + 1;
      else left_cnt <= left_cnt + 1;
      if (gap != 0 && gap < min_gap) min_gap <= gap;
      gap <= 1;
      if (drv_enable !== 1'b1) bad_cnt <= bad_cnt + 1;
    end
  end
endmodule // dios_ext_partner

`default_nettype wire

/* tb/tb.sv */
// Purpose: self-checking bench of the digital io and step output block
// Assumes: zero wait bus slave, debounce shortened to 20 cycles
// Notes: pulse counters survive resets so restart firing stays visible
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end

module tb;
  localparam int FMIN = (100000000 + 77999) / 78000;
  logic        sys_clk, rst, hsel, hwrite, hreadyout, hresp, pin, ext_oe, ext_lvl, bo_d;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [4:0]  mi;
  logic [3:0]  cmd;
  logic        bridge_off, gpio_out, gpio_oe, drv_enable, drv_dir, drv_step, irq;
  logic [1:0]  evs [3] = '{2'h0, 2'h2, 2'h3};
  int          right_cnt, left_cnt, min_gap, bad_cnt, num_errors, checks_done;
  int          cnt [5];
  int          exp [5];

  dios_top #(.DEB_CYCLES(20'h14)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .gpio_in(pin),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .motion_moving(mi[0]),
    .motion_windings_on(mi[1]), .motion_motor_present(mi[2]),
    .motion_step_req(mi[3]), .motion_step_dir(mi[4]), .quick_stop_cmd(cmd[0]),
    .winding_power_off_cmd(cmd[1]), .relative_shift_cmd(cmd[2]), .home_cmd(cmd[3]),
    .bridge_off(bridge_off), .drv_enable(drv_enable), .drv_dir(drv_dir),
    .drv_step(drv_step), .irq(irq));

  dios_ext_partner i_far (
    .sys_clk(sys_clk), .rst(rst), .drv_enable(drv_enable), .drv_dir(drv_dir),
    .drv_step(drv_step), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .ext_oe(ext_oe),
    .ext_lvl(ext_lvl), .pin(pin), .right_cnt(right_cnt), .left_cnt(left_cnt),
    .min_gap(min_gap), .bad_cnt(bad_cnt));

  always #5 sys_clk = ~sys_clk;

  // command pulses and alarm entries, counted on the settled edge value
  always @(posedge sys_clk) begin
    bo_d <= bridge_off;
    for (int k = 0; k < 4; k++) if (cmd[k] === 1'b1) cnt[k]++;
    if (bridge_off === 1'b1 && bo_d !== 1'b1) cnt[4]++;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // one edge, then poll the ready under a bound
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      num_errors++;
      print_verdict();
    end
  endtask

  // single word transfer; read data taken at the edge closing the data phase
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    `CHK(r & m, e)
    `CHK(hresp, 1'b0)
  endtask

  // the outside equipment drives the pin active for n cycles
  task automatic pulse(input int n);
    ext_oe <= 1'b1;
    ext_lvl <= 1'b1;
    cyc(n);
    ext_oe <= 1'b0;
    ext_lvl <= 1'b0;
    cyc(15);
  endtask

  // up to 8000 cycles for the step count to reach n
  task automatic wait_steps(input int n);
    int k;
    k = 0;
    while (right_cnt + left_cnt < n && k < 8000) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 8000) begin
      num_errors++;
      print_verdict();
    end
  endtask

  task automatic step_reqs(input int n, input logic dir);
    repeat (n) begin
      mi <= {dir, 4'hb};
      cyc(1);
      mi <= {dir, 4'h3};
      cyc(1);
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata, mi, ext_oe, ext_lvl} = '0;
    hsize = 3'h2;
    cyc(12);
    rst <= 1'b0;
    cyc(1);
    rd_chk(32'h00, 32'h0, 32'hffff_ffff);
    wr(32'h00, 32'hffff_ffff);
    rd_chk(32'h00, 32'hff, 32'hffff_ffff);
    wr(32'h00, 32'h0);
    wr(32'h20, 32'h5a);
    rd_chk(32'h20, 32'h0, 32'hffff_ffff);
    rd_chk(32'h04, 32'h0, 32'h3);
    $display("test registers done");
    wr(32'h10, 32'h1);
    exp = cnt;
    pulse(10);
    `CHK(cnt[0], exp[0])
    pulse(40);
    `CHK(cnt[0], exp[0] + 1)
    `CHK(irq, 1'b1)
    rd_chk(32'h08, 32'h1, 32'h1);
    wr(32'h0c, 32'h1);
    cyc(3);
    `CHK(irq, 1'b0)
    wr(32'h10, 32'h0);
    pulse(40);
    `CHK(irq, 1'b0)
    $display("test debounce and interrupt done");
    exp = cnt;
    for (int a = 0; a < 5; a++) begin
      wr(32'h00, 32'(a) << 2);
      pulse(40);
      exp[a]++;
      for (int k = 0; k < 5; k++) `CHK(cnt[k], exp[k])
    end
    `CHK(bridge_off, 1'b1)
    wr(32'h00, 32'h0000_0021);
    cyc(3);
    `CHK({gpio_oe, gpio_out}, 2'h3)
    wr(32'h00, 32'h0000_0121);
    cyc(3);
    `CHK({bridge_off, gpio_out}, 2'h0)
    $display("test actions and alarm done");
    for (int i = 0; i < 3; i++) begin
      wr(32'h00, {25'h0, evs[i], 5'h01});
      mi <= 5'h07 & ~(5'h01 << i);
      cyc(4);
      `CHK(gpio_out, 1'b0)
      mi <= 5'h01 << i;
      cyc(4);
      `CHK(gpio_out, 1'b1)
    end
    mi <= 5'h0;
    exp = cnt;
    wr(32'h00, 32'h2);
    cyc(30);
    `CHK(cnt[0], exp[0] + 1)
    rd_chk(32'h04, 32'h1, 32'h1);
    wr(32'h00, 32'h0);
    $display("test output events and invert done");
    mi <= 5'h02;
    wr(32'h00, 32'h80);
    cyc(3);
    `CHK({drv_enable, gpio_oe, gpio_out}, 3'h7)
    step_reqs(3, 1'b1);
    wait_steps(3);
    step_reqs(2, 1'b0);
    wait_steps(5);
    `CHK(right_cnt, 3)
    `CHK(left_cnt, 2)
    `CHK(min_gap >= FMIN, 1'b1)
    `CHK(bad_cnt, 0)
    mi <= 5'h0;
    cyc(3);
    `CHK(drv_enable, 1'b0)
    wr(32'h00, 32'h0);
    mi <= 5'h02;
    step_reqs(1, 1'b1);
    cyc(1400);
    `CHK(right_cnt + left_cnt, 5)
    $display("test step port done");
    exp = cnt;
    ext_oe <= 1'b1;
    ext_lvl <= 1'b1;
    rst <= 1'b1;
    cyc(12);
    rst <= 1'b0;
    cyc(40);
    `CHK(cnt[0], exp[0] + 1)
    $display("test restart with active pin done");
    print_verdict();
  end
endmodule // tb

`default_nettype wire
